// >>> tone_pair_receive_steering_bench.sv
`timescale 1ns/10ps
`include "tprs_defs.svh"
// bench: host on the bus, tone pairs and steering capacitor on the pins
module tone_pair_receive_steering_bench;
  import tprs_pkg::*;
  localparam int          RC_CYC     = 40;                    // capacitor charge time
  localparam int          LIMIT      = 90000;                 // cycle ceiling
  localparam logic [63:0] PAIRS      = 64'hB73E_CDA9_8654_210F; // {low,high} index per code
  int           lof [4]    = '{697, 770, 852, 941};
  int           hif [4]    = '{1209, 1336, 1477, 1633};
  logic         clk_i      = 1'b0;
  logic         rst_i      = 1'b1;
  tprs_wb_req_t wb_req;
  logic [31:0]  wb_dat_o;
  logic         wb_ack_o, guard_o, guard_oe_n, early_steer_o, irq_od, irq_oe_n, irq_o, steer_pin;
  logic [1:0]   sq         = 2'b00;   // low and high comparator waves
  int           inc [2]    = '{0, 0}; // scaled tone rate, 0 is silence
  int           ph [2]     = '{0, 0}; // phase accumulators
  int           rc_cnt     = 0;       // capacitor charge
  logic [3:0]   nibble;
  logic [31:0]  exp_q [$];            // noted read words, oldest first
  int           num_errors = 0;
  int           compares   = 0;
  int           cyc_cnt    = 0;
  int           c, off, msk;
  logic [19:0]  gtp;
  // capacitor sets the pin unless the guard drives it
  assign steer_pin = guard_oe_n ? (rc_cnt >= RC_CYC / 2) : guard_o;
  tprs_core u_tprs_core (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .low_sq_i(sq[0]), .high_sq_i(sq[1]), .steer_in_guard_out_i(steer_pin), .steer_in_guard_out_o(guard_o),
    .steer_in_guard_out_oe_n_o(guard_oe_n), .early_steer_o(early_steer_o), .irq_or_tone_out_o(irq_od),
    .irq_or_tone_out_oe_n_o(irq_oe_n), .host_nibble_bus_o(nibble), .irq_o(irq_o));
  tprs_host u_tprs_host (.clk_i(clk_i), .wb_ack_i(wb_ack_o), .wb_req_o(wb_req));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // tone waves and capacitor charge move on the rising edge
  always @(posedge clk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (ph[k] + inc[k] >= `TPRS_CLK_HZ / 2) begin
        ph[k] <= ph[k] + inc[k] - `TPRS_CLK_HZ / 2;
        sq[k] <= ~sq[k];
      end else begin
        ph[k] <= ph[k] + inc[k];
      end
    end
    if (!guard_oe_n) rc_cnt <= RC_CYC;
    else if (early_steer_o && rc_cnt < RC_CYC) rc_cnt <= rc_cnt + 1;
    else if (!early_steer_o && rc_cnt > 0) rc_cnt <= rc_cnt - 1;
  end
  // watcher: acked reads against oldest note, plus the hang limit
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (wb_ack_o === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0) chk(wb_dat_o, exp_q.pop_front());
    if (cyc_cnt == LIMIT) begin
      num_errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  function automatic logic pin(input int s);
    return (s == 0) ? early_steer_o : (s == 1) ? guard_oe_n : irq_oe_n;
  endfunction
  // bounded wait for a pin level, then compare
  task automatic wait_pin(input int s, input logic lvl, input int lim);
    int n;
    n = 0;
    while (pin(s) !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk_bit(pin(s), lvl);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_tprs_host.xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_tprs_host.xfer(1'b1, a, d);
  endtask
  // start the pair of a code, or silence for a negative code
  task automatic tone(input int code);
    logic [3:0] p;
    p = (code < 0) ? 4'h0 : PAIRS[4*code +: 4];
    inc[0] <= (code < 0) ? 0 : lof[p[3:2]] * `TPRS_TONE_SCALE;
    inc[1] <= (code < 0) ? 0 : hif[p[1:0]] * `TPRS_TONE_SCALE;
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h6227));
    off = $urandom % 16;
    gtp = 20'h0_0064 + 20'($urandom % 64);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`TPRS_ADDR_GTP, 32'h0000_9C40);
    rd(`TPRS_ADDR_MASK, 32'h0000_0004);
    rd(`TPRS_ADDR_STATUS, 32'h0000_0000);
    rd(`TPRS_ADDR_RXDATA, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
    wr(`TPRS_ADDR_CTRL, 32'h0000_0001);
    wr(`TPRS_ADDR_GTP, {12'h000, gtp});
    wr(`TPRS_ADDR_GTA, 32'h0000_0064);
    rd(`TPRS_ADDR_GTP, {12'h000, gtp});
    // every code once, one of them with the interrupt masked
    for (int i = 0; i < 16; i++) begin
      c = (i + off) % 16;
      msk = (i == 5) ? 0 : 4;
      wr(`TPRS_ADDR_MASK, msk);
      tone(c);
      wait_pin(0, 1'b1, 9000);
      wait_pin(1, 1'b0, 600);
      wait_pin(2, 1'b0, 40);
      chk_bit(irq_o, msk != 0);
      chk({28'h000_0000, nibble}, c);
      rd(`TPRS_ADDR_RXDATA, c);
      rd(`TPRS_ADDR_STATUS, 32'h0000_000E);
      rd(`TPRS_ADDR_STATUS, 32'h0000_000A);
      chk_bit(irq_oe_n, 1'b1);
      chk_bit(irq_o, 1'b0);
      tone(-1);
      wait_pin(0, 1'b0, 9000);
      wait_pin(1, 1'b1, 4);
      repeat (RC_CYC + 200) @(posedge clk_i);
    end
    // a tone shorter than a long guard time registers nothing
    wr(`TPRS_ADDR_STATUS, 32'h0000_0002);
    rd(`TPRS_ADDR_STATUS, 32'h0000_0000);
    wr(`TPRS_ADDR_GTP, 32'h0000_4000);
    tone(5);
    repeat (6000) @(posedge clk_i);
    tone(-1);
    wait_pin(0, 1'b0, 9000);
    repeat (RC_CYC + 200) @(posedge clk_i);
    rd(`TPRS_ADDR_RXDATA, c);
    rd(`TPRS_ADDR_STATUS, 32'h0000_0002);
    chk_bit(irq_od, 1'b0);
    results();
  end
endmodule

// >>> tprs_core.sv
`timescale 1ns/10ps
`include "tprs_defs.svh"
module tprs_core
  import tprs_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire tprs_pkg::tprs_wb_req_t wb_req_i,   // wishbone request
  output logic [31:0]                wb_dat_o,   // read data
  output logic                       wb_ack_o,   // ack
  input  wire logic                  low_sq_i,   // low group comparator
  input  wire logic                  high_sq_i,  // high group comparator
  input  wire logic                  steer_in_guard_out_i,  // steer pin level
  output logic                       steer_in_guard_out_o,  // guard drive value
  output logic                       steer_in_guard_out_oe_n_o, // low while driving
  output logic                       early_steer_o,          // early steering
  output logic                       irq_or_tone_out_o,      // open-drain value (0)
  output logic                       irq_or_tone_out_oe_n_o, // low pulls pin low
  output logic [3:0]                 host_nibble_bus_o,      // latched code
  output logic                       irq_o                   // level interrupt
);
  import tprs_pkg::*;

  logic [15:0] low_cnt, high_cnt;     // measured edge counts
  logic        low_done, high_done;   // window pulses
  logic [2:0]  low_idx_r, high_idx_r; // matched tone index, bit2 = valid
  logic [2:0]  low_prev_r, high_prev_r; // result of the window before
  logic        cond;                  // signal condition
  logic [3:0]  code_now;              // code of current pair
  logic [3:0]  pend_code_r;           // code latched at registration
  logic [3:0]  rx_code_r;             // output latch
  logic        steer_s1_r, steer_s2_r;// steer synchroniser
  tprs_state_t state_r;               // steering sequencer
  logic [19:0] tmr_r;                 // guard and settle timer
  logic [19:0] gtp_r, gta_r;          // programmable guard counts
  logic        dsteer_r;              // delayed steering flag
  logic [3:0]  stat_r;                // sticky event bits
  logic [3:0]  mask_r;                // interrupt mask
  logic        ctrl_irq_r;            // interrupt mode select
  logic        acc;                   // bus access this cycle
  logic        early_steer_r;         // internal early steer
  logic        ev_valid, ev_early;    // event pulses
  logic        rd_status;             // status read strobe
  logic        wr_ack;                // write lands at the acknowledged edge

  // expected edge count for a frequency in one window
  function automatic logic [15:0] f_exp(input int hz);
    f_exp = 16'(hz * `TPRS_TONE_SCALE / (`TPRS_CLK_HZ / `TPRS_WIN_CYC));
  endfunction

  // match a count against four standard tones, returns {hit, index}
  function automatic logic [2:0] f_match(input logic [15:0] c, input int f0, input int f1,
                                         input int f2, input int f3);
    int          fl [4];
    logic [15:0] e, t;
    f_match = 3'b000;
    fl[0] = f0;
    fl[1] = f1;
    fl[2] = f2;
    fl[3] = f3;
    for (int i = 0; i < 4; i++) begin
      e = f_exp(fl[i]);
      t = 16'(e * `TPRS_TOL_PCT / 100) + 16'h0001;
      if (c + t >= e && c <= e + t) begin
        f_match = {1'b1, 2'(i)};
      end
    end
  endfunction

  // frequency counters for each group
  tprs_freq_meas u_low (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .sq_i   (low_sq_i),
    .count_o(low_cnt),
    .done_o (low_done)
  );
  tprs_freq_meas u_high (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .sq_i   (high_sq_i),
    .count_o(high_cnt),
    .done_o (high_done)
  );

  // classify each window result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_idx_r   <= 3'b000;
      high_idx_r  <= 3'b000;
      low_prev_r  <= 3'b000;
      high_prev_r <= 3'b000;
    end else begin
      if (low_done) begin
        low_prev_r <= low_idx_r;
        low_idx_r  <= f_match(low_cnt, 697, 770, 852, 941);
      end
      if (high_done) begin
        high_prev_r <= high_idx_r;
        high_idx_r  <= f_match(high_cnt, 1209, 1336, 1477, 1633);
      end
    end
  end

  // both groups valid gives the signal condition
  // two windows in a row must agree, so a part-filled window never steers a wrong pair
  assign cond = low_idx_r[2] & high_idx_r[2] & (low_idx_r == low_prev_r) & (high_idx_r == high_prev_r);

  // pair to code table
  always_comb begin
    case ({low_idx_r[1:0], high_idx_r[1:0]})
      4'h0: code_now = 4'h1;
      4'h1: code_now = 4'h2;
      4'h2: code_now = 4'h3;
      4'h4: code_now = 4'h4;
      4'h5: code_now = 4'h5;
      4'h6: code_now = 4'h6;
      4'h8: code_now = 4'h7;
      4'h9: code_now = 4'h8;
      4'hA: code_now = 4'h9;
      4'hD: code_now = 4'hA;
      4'hC: code_now = 4'hB;
      4'hE: code_now = 4'hC;
      4'h3: code_now = 4'hD;
      4'h7: code_now = 4'hE;
      4'hB: code_now = 4'hF;
      default: code_now = 4'h0;
    endcase
  end

  // early steering follows the signal condition each cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      early_steer_r <= 1'b0;
      early_steer_o <= 1'b0;
    end else begin
      early_steer_r <= cond;
      early_steer_o <= cond;
    end
  end

  // steer pin synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      steer_s1_r <= 1'b0;
      steer_s2_r <= 1'b0;
    end else begin
      steer_s1_r <= steer_in_guard_out_i;
      steer_s2_r <= steer_s1_r;
    end
  end

  // steering sequencer: present guard, settle, held, absent guard
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= ST_IDLE;
      tmr_r       <= 20'h0_0000;
      pend_code_r <= 4'h0;
      dsteer_r    <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          tmr_r <= 20'h0_0000;
          if (early_steer_r) begin
            state_r <= ST_QUAL;
          end
        end
        ST_QUAL: begin
          if (!early_steer_r) begin
            state_r <= ST_IDLE;
          end else if (tmr_r >= gtp_r && steer_s2_r) begin
            pend_code_r <= code_now;
            tmr_r       <= 20'h0_0000;
            state_r     <= ST_SETTLE;
          end else if (tmr_r < gtp_r) begin
            tmr_r <= tmr_r + 20'h0_0001;
          end
        end
        ST_SETTLE: begin
          if (tmr_r[3:0] == `TPRS_SETTLE_CYC) begin
            dsteer_r <= 1'b1;
            state_r  <= ST_HELD;
          end else begin
            tmr_r <= tmr_r + 20'h0_0001;
          end
        end
        ST_HELD: begin
          tmr_r <= 20'h0_0000;
          if (!early_steer_r) begin
            state_r <= ST_ABSENT;
          end
        end
        ST_ABSENT: begin
          if (early_steer_r) begin
            state_r <= ST_HELD;
          end else if (tmr_r >= gta_r && !steer_s2_r) begin
            dsteer_r <= 1'b0;
            state_r  <= ST_IDLE;
          end else if (tmr_r < gta_r) begin
            tmr_r <= tmr_r + 20'h0_0001;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // guard output drives high while early steer holds after registration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      steer_in_guard_out_o      <= 1'b0;
      steer_in_guard_out_oe_n_o <= 1'b1;
    end else begin
      steer_in_guard_out_o      <= 1'b1;
      steer_in_guard_out_oe_n_o <= !(cond && (state_r == ST_SETTLE || state_r == ST_HELD
                                              || (state_r == ST_QUAL && tmr_r >= gtp_r && steer_s2_r)));
    end
  end

  // output latch loads on rising delayed steering
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_code_r         <= 4'h0;
      host_nibble_bus_o <= 4'h0;
    end else if (state_r == ST_SETTLE && tmr_r[3:0] == `TPRS_SETTLE_CYC) begin
      rx_code_r         <= pend_code_r;
      host_nibble_bus_o <= pend_code_r;
    end
  end

  // bus decode
  assign acc       = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  assign rd_status = acc & ~wb_req_i.we & (wb_req_i.adr == `TPRS_ADDR_STATUS);
  assign wr_ack    = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & wb_ack_o;
  assign ev_valid  = state_r == ST_SETTLE && tmr_r[3:0] == `TPRS_SETTLE_CYC;
  assign ev_early  = cond & ~early_steer_r;

  // sticky events: set wins, valid cleared by status read, any bit by write-one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (i == `TPRS_ST_VALID && ev_valid) begin
          stat_r[i] <= 1'b1;
        end else if (i == `TPRS_ST_EARLY && ev_early) begin
          stat_r[i] <= 1'b1;
        end else if (rd_status && i == `TPRS_ST_VALID) begin
          stat_r[i] <= 1'b0;
        end else if (wr_ack && wb_req_i.sel[0] && wb_req_i.adr == `TPRS_ADDR_STATUS
                     && wb_req_i.dat[i]) begin
          stat_r[i] <= 1'b0;
        end
      end
    end
  end

  // writable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r     <= `TPRS_MASK_RST;
      ctrl_irq_r <= `TPRS_CTRL_RST;
      gtp_r      <= `TPRS_GTP_RST;
      gta_r      <= `TPRS_GTA_RST;
    end else if (wr_ack) begin
      case (wb_req_i.adr)
        `TPRS_ADDR_MASK: if (wb_req_i.sel[0]) mask_r <= wb_req_i.dat[3:0];
        `TPRS_ADDR_CTRL: if (wb_req_i.sel[0]) ctrl_irq_r <= wb_req_i.dat[`TPRS_CTRL_IRQ_EN];
        `TPRS_ADDR_GTP: begin
          if (wb_req_i.sel[0]) gtp_r[7:0]   <= wb_req_i.dat[7:0];
          if (wb_req_i.sel[1]) gtp_r[15:8]  <= wb_req_i.dat[15:8];
          if (wb_req_i.sel[2]) gtp_r[19:16] <= wb_req_i.dat[19:16];
        end
        `TPRS_ADDR_GTA: begin
          if (wb_req_i.sel[0]) gta_r[7:0]   <= wb_req_i.dat[7:0];
          if (wb_req_i.sel[1]) gta_r[15:8]  <= wb_req_i.dat[15:8];
          if (wb_req_i.sel[2]) gta_r[19:16] <= wb_req_i.dat[19:16];
        end
        default: ;
      endcase
    end
  end

  // read mux and single-cycle ack; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_req_i.we) begin
        case (wb_req_i.adr)
          `TPRS_ADDR_RXDATA: wb_dat_o <= {28'h000_0000, rx_code_r};
          `TPRS_ADDR_STATUS: wb_dat_o <= {28'h000_0000, dsteer_r, stat_r[2:0]};
          `TPRS_ADDR_CTRL:   wb_dat_o <= {31'h0000_0000, ctrl_irq_r};
          `TPRS_ADDR_MASK:   wb_dat_o <= {28'h000_0000, mask_r};
          `TPRS_ADDR_GTP:    wb_dat_o <= {12'h000, gtp_r};
          `TPRS_ADDR_GTA:    wb_dat_o <= {12'h000, gta_r};
          default:           wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // interrupt outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o                  <= 1'b0;
      irq_or_tone_out_o      <= 1'b0;
      irq_or_tone_out_oe_n_o <= 1'b1;
    end else begin
      irq_o                  <= |(stat_r & mask_r);
      irq_or_tone_out_o      <= 1'b0;
      irq_or_tone_out_oe_n_o <= !(ctrl_irq_r && dsteer_r && stat_r[`TPRS_ST_VALID]);
    end
  end
endmodule

// >>> tprs_core_checker.sv
`timescale 1ns/10ps
`include "tprs_defs.svh"
// port-level checks on the steering core
module tprs_core_checker
  import tprs_pkg::*;
(
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire tprs_pkg::tprs_wb_req_t wb_req_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire logic                   steer_in_guard_out_o,
  input wire logic                   steer_in_guard_out_oe_n_o,
  input wire logic                   early_steer_o,
  input wire logic [3:0]             host_nibble_bus_o
);
  // one clock domain, reset silences every check
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answers exactly once, one cycle after the request is taken
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_after_req: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_rxdata_read_code: assert property (
    wb_ack_o && !$past(wb_req_i.we) && $past(wb_req_i.adr) == `TPRS_ADDR_RXDATA
    |-> wb_dat_o == {28'h000_0000, $past(host_nibble_bus_o)}) else $error("read data is not the code");
  // guard drives high, only around early steering
  a_guard_drives_high: assert property (!steer_in_guard_out_oe_n_o |-> steer_in_guard_out_o)
    else $error("guard drives low");
  a_guard_needs_early: assert property (!steer_in_guard_out_oe_n_o
    |-> early_steer_o || $past(early_steer_o) || $past(early_steer_o, 2)) else $error("guard without early");
  a_guard_after_early: assert property ($fell(steer_in_guard_out_oe_n_o) |-> $past(early_steer_o))
    else $error("registration without early");
  a_no_early_guard: assert property ($rose(early_steer_o) |-> steer_in_guard_out_oe_n_o [*8])
    else $error("registered before guard time");
  a_latch_with_guard: assert property ($changed(host_nibble_bus_o)
    |-> !steer_in_guard_out_oe_n_o || !$past(steer_in_guard_out_oe_n_o)) else $error("latch moved unregistered");
endmodule
bind tprs_core tprs_core_checker u_tprs_core_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .steer_in_guard_out_o(steer_in_guard_out_o), .steer_in_guard_out_oe_n_o(steer_in_guard_out_oe_n_o),
  .early_steer_o(early_steer_o), .host_nibble_bus_o(host_nibble_bus_o));

// >>> tprs_defs.svh
`ifndef TPRS_DEFS_SVH
`define TPRS_DEFS_SVH
// register word addresses (byte offsets, one aligned word each)
`define TPRS_ADDR_RXDATA   8'h00
`define TPRS_ADDR_STATUS   8'h04
`define TPRS_ADDR_CTRL     8'h08
`define TPRS_ADDR_MASK     8'h0C
`define TPRS_ADDR_GTP      8'h10
`define TPRS_ADDR_GTA      8'h14
// status bit positions
`define TPRS_ST_DSTEER     3
`define TPRS_ST_VALID      2
`define TPRS_ST_EARLY      1
// ctrl bit positions
`define TPRS_CTRL_IRQ_EN   0
// reset values
`define TPRS_GTP_RST       20'h0_9C40
`define TPRS_GTA_RST       20'h0_9C40
`define TPRS_MASK_RST      4'h4
`define TPRS_CTRL_RST      1'b0
// frequency measurement
`define TPRS_CLK_HZ        100000000
`define TPRS_WIN_CYC       16'h0320
// comparator waves arrive this many times the nominal tone rate, so a short window still counts dozens of edges
`define TPRS_TONE_SCALE    6250
`define TPRS_TOL_PCT       2
`define TPRS_SETTLE_CYC    4'h4
`endif

// >>> tprs_freq_meas.sv
`timescale 1ns/10ps
`include "tprs_defs.svh"
// counts rising edges of one comparator output over a fixed window
module tprs_freq_meas (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        sq_i,     // limited tone square wave
  output logic [15:0]      count_o,  // edges in last window
  output logic             done_o    // one-cycle pulse per window
);
  logic        sq_d_r;   // previous sample
  logic [15:0] win_r;    // window timer
  logic [15:0] edge_r;   // running edge count
  // edge counting and window timing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sq_d_r  <= 1'b0;
      win_r   <= 16'h0000;
      edge_r  <= 16'h0000;
      count_o <= 16'h0000;
      done_o  <= 1'b0;
    end else begin
      sq_d_r <= sq_i;
      done_o <= 1'b0;
      if (win_r == `TPRS_WIN_CYC - 16'h0001) begin
        win_r   <= 16'h0000;
        count_o <= edge_r + {15'h0000, sq_i & ~sq_d_r};
        edge_r  <= 16'h0000;
        done_o  <= 1'b1;
      end else begin
        win_r <= win_r + 16'h0001;
        if (sq_i && !sq_d_r) begin
          edge_r <= edge_r + 16'h0001;
        end
      end
    end
  end
endmodule

// >>> tprs_host.sv
`timescale 1ns/10ps
// host side: classic wishbone single cycles, one at a time
module tprs_host
  import tprs_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              wb_ack_i,
  output tprs_pkg::tprs_wb_req_t wb_req_o
);
  // idle bus before the first cycle
  initial wb_req_o = '0;
  // raise after an edge, hold until ack is sampled, then release
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_i !== 1'b1 && n < 1000);
    // released lines stop showing the old request
    wb_req_o <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: 4'h0, dat: ~dat};
    @(posedge clk_i);
  endtask
endmodule

// >>> tprs_pkg.sv
package tprs_pkg;
  // wishbone request from master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tprs_wb_req_t;
  // steering sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_QUAL, ST_SETTLE, ST_HELD, ST_ABSENT} tprs_state_t;
endpackage
